// *** cdem_pkg.sv ***
// Purpose: shared constants and types for the channel decoder monitor
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: dwell and timeouts count clock cycles or decoded bits; lock and clean counts are in blocks and bytes
`default_nettype none
package cdem_pkg;
  localparam int CLK_HZ = 50_000_000;
  // code-rate search: five rates, sixteen phase/rotation/swap trials each
  localparam int NUM_RATES = 5;
  localparam logic [2:0] LAST_RATE = 3'h4;
  localparam logic [3:0] LAST_HYP = 4'hf;
  localparam logic [11:0] DWELL_CYC = 12'h400;
  // frame sync values and block lengths (sync byte included)
  localparam logic [7:0] SYNC_MAIN = 8'h47;
  localparam logic [7:0] SYNC_ALT = 8'h1d;
  localparam logic [7:0] BLK_LEN_MAIN = 8'hcc;
  localparam logic [7:0] BLK_LEN_ALT = 8'h93;
  localparam logic [2:0] LOCK_BLOCKS = 3'h3;
  localparam logic [15:0] FS_TIMEOUT_BITS = 16'h2000;
  // pattern checker: x^23 + x^18 + 1
  localparam int PRBS_LEN = 23;
  localparam int PRBS_TAP = 18;
  localparam logic [2:0] PAT_CLEAN_BYTES = 3'h4;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  typedef enum logic [1:0] {
    ERR_BIT, ERR_BYTE, ERR_PKT, ERR_PRBS
  } cdem_errtype_t;
  typedef struct packed {
    logic [2:0] rate;
    logic [1:0] phase;
    logic rot;
    logic swap;
  } cdem_hyp_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic sop;
  } cdem_byte_t;
  typedef struct packed {
    logic [3:0] bit_errs;
    logic byte_err;
    logic pkt_uncorr;
    logic pkt_done;
  } cdem_blkerr_t;
endpackage
`default_nettype wire

// *** cdem_top.sv ***
// Purpose: decoder search control, error counters, frame sync, pattern test
// Assumes: decoder core and block decoder run on CLK_I
// Notes: start bits are set/clear port pairs; set wins over clear
`timescale 1ns/1ns
`default_nettype none
module cdem_top
  import cdem_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic DEC_SEARCH_GO_I,
  input wire logic FRAME_SYNC_GO_I,
  input wire logic ACQ_ABORT_I,
  input wire logic [4:0] CODE_RATE_SELECT_I,
  input wire logic DEC_IN_SYNC_I,
  input wire logic DEC_BIT_VALID_I,
  input wire logic DEC_BIT_I,
  input wire logic DEC_BIT_ERR_I,
  input wire logic ALT_FORMAT_I,
  input wire logic DECODER_ERR_WINDOW_MODE_I,
  input wire logic [15:0] DECODER_ERR_WINDOW_SIZE_I,
  input wire logic DECODER_ERR_START_SET_I,
  input wire logic DECODER_ERR_START_CLR_I,
  input wire cdem_errtype_t BLOCK_ERR_TYPE_SELECT_I,
  input wire logic BLOCK_ERR_WINDOW_MODE_I,
  input wire logic [15:0] BLOCK_ERR_WINDOW_SIZE_I,
  input wire logic BLOCK_ERR_START_SET_I,
  input wire logic BLOCK_ERR_START_CLR_I,
  input wire cdem_blkerr_t BLK_ERR_I,
  input wire cdem_byte_t BLK_BYTE_I,
  input wire logic [3:0] PATTERN_HEADER_SKIP_I,
  input wire logic BLOCK_DECODER_BYPASS_I,
  input wire logic DEINTERLEAVER_BYPASS_I,
  output cdem_hyp_t HYP_O,
  output logic DECODER_LOCK_FLAG_O,
  output logic DECODER_SEARCH_FAIL_FLAG_O,
  output cdem_hyp_t FOUND_STATUS_O,
  output logic [15:0] DECODER_ERR_COUNT_O,
  output logic DECODER_ERR_START_O,
  output logic DECODER_ERR_DONE_O,
  output logic [15:0] BLOCK_ERR_COUNT_O,
  output logic BLOCK_ERR_START_O,
  output logic BLOCK_ERR_DONE_O,
  output logic PATTERN_SYNC_FLAG_O,
  output logic FRAME_LOCK_FLAG_O,
  output logic FRAME_SYNC_FAIL_FLAG_O,
  output cdem_byte_t FS_BYTE_O,
  output logic DEINTERLEAVER_BYPASS_O
);

  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [3:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {13'h0, b};
    return s[16] ? CNT_MAX : s[15:0];
  endfunction

  // ===========================================================
  // code-rate search
  typedef enum logic [1:0] {SR_IDLE, SR_TRY, SR_LOCK, SR_FAIL} cdem_sr_t;
  cdem_sr_t sr_reg;
  logic [11:0] dwell_reg;
  logic rate_en;
  assign rate_en = CODE_RATE_SELECT_I[HYP_O.rate];

  always_ff @(posedge CLK_I) begin
    if (RST_I || ACQ_ABORT_I) begin
      sr_reg <= SR_IDLE;
      HYP_O <= '0;
      dwell_reg <= '0;
    end else begin
      unique case (sr_reg)
        SR_IDLE, SR_LOCK, SR_FAIL: begin
          if (DEC_SEARCH_GO_I) begin
            sr_reg <= SR_TRY;
            HYP_O <= '0;
            dwell_reg <= '0;
          end
        end
        SR_TRY: begin
          if (rate_en && DEC_IN_SYNC_I) begin
            sr_reg <= SR_LOCK;
          end else if (!rate_en || dwell_reg == DWELL_CYC) begin
            dwell_reg <= '0;
            if ({HYP_O.phase, HYP_O.rot, HYP_O.swap} == LAST_HYP ||
                !rate_en) begin
              HYP_O.phase <= '0;
              HYP_O.rot <= 1'b0;
              HYP_O.swap <= 1'b0;
              HYP_O.rate <= HYP_O.rate + 3'h1;
              if (HYP_O.rate == LAST_RATE) sr_reg <= SR_FAIL;
            end else begin
              {HYP_O.phase, HYP_O.rot, HYP_O.swap} <=
                {HYP_O.phase, HYP_O.rot, HYP_O.swap} + 4'h1;
            end
          end else begin
            dwell_reg <= dwell_reg + 12'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    // a go while trying is ignored, so it must not wipe the flags either
    if (RST_I || ACQ_ABORT_I || (DEC_SEARCH_GO_I && sr_reg != SR_TRY)) begin
      DECODER_LOCK_FLAG_O <= 1'b0;
      DECODER_SEARCH_FAIL_FLAG_O <= 1'b0;
    end else begin
      if (sr_reg == SR_TRY && rate_en && DEC_IN_SYNC_I)
        DECODER_LOCK_FLAG_O <= 1'b1;
      if (sr_reg == SR_TRY && HYP_O.rate == LAST_RATE &&
          (!rate_en || (!DEC_IN_SYNC_I && dwell_reg == DWELL_CYC &&
          {HYP_O.phase, HYP_O.rot, HYP_O.swap} == LAST_HYP)))
        DECODER_SEARCH_FAIL_FLAG_O <= 1'b1;
    end
  end

  // status captured once so later hypotheses cannot disturb it
  always_ff @(posedge CLK_I) begin
    if (RST_I) FOUND_STATUS_O <= '0;
    else if (sr_reg == SR_TRY && rate_en && DEC_IN_SYNC_I)
      FOUND_STATUS_O <= HYP_O;
  end

  // ===========================================================
  // decoder-input error counter
  logic [15:0] dwin_reg;
  logic dwin_end;
  assign dwin_end = DECODER_ERR_START_O && !DECODER_ERR_WINDOW_MODE_I &&
                    DEC_BIT_VALID_I &&
                    dwin_reg + 16'h1 >= DECODER_ERR_WINDOW_SIZE_I;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      DECODER_ERR_START_O <= 1'b0;
      DECODER_ERR_COUNT_O <= '0;
      dwin_reg <= '0;
      DECODER_ERR_DONE_O <= 1'b0;
    end else begin
      DECODER_ERR_DONE_O <= dwin_end;
      if (DECODER_ERR_START_SET_I) begin
        DECODER_ERR_START_O <= 1'b1;
        DECODER_ERR_COUNT_O <= '0;
        dwin_reg <= '0;
      end else begin
        if (DECODER_ERR_START_CLR_I || dwin_end)
          DECODER_ERR_START_O <= 1'b0;
        if (DECODER_ERR_START_O && DEC_BIT_VALID_I) begin
          dwin_reg <= dwin_reg + 16'h1;
          DECODER_ERR_COUNT_O <= sat_add(DECODER_ERR_COUNT_O,
                                         {3'h0, DEC_BIT_ERR_I});
        end
      end
    end
  end

  // ===========================================================
  // frame synchronizer
  typedef enum logic [2:0] {
    FS_IDLE, FS_HUNT, FS_VERIFY, FS_LOCK, FS_FAIL
  } cdem_fs_t;
  cdem_fs_t fs_reg;
  logic [7:0] sh_reg, sh_next, sync_val, blk_len, pos_reg;
  logic [2:0] bitc_reg, conf_reg;
  logic [15:0] tmo_reg;
  logic inv_reg, byte_done;
  assign sh_next = {sh_reg[6:0], DEC_BIT_I};
  assign sync_val = ALT_FORMAT_I ? SYNC_ALT : SYNC_MAIN;
  assign blk_len = ALT_FORMAT_I ? BLK_LEN_ALT : BLK_LEN_MAIN;
  assign byte_done = DEC_BIT_VALID_I && bitc_reg == 3'h7;

  always_ff @(posedge CLK_I) begin
    if (RST_I) sh_reg <= '0;
    else if (DEC_BIT_VALID_I) sh_reg <= sh_next;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || ACQ_ABORT_I) begin
      fs_reg <= FS_IDLE;
      bitc_reg <= '0;
      pos_reg <= '0;
      conf_reg <= '0;
      tmo_reg <= '0;
      inv_reg <= 1'b0;
    end else if (FRAME_SYNC_GO_I) begin
      fs_reg <= FS_HUNT;
      tmo_reg <= '0;
      conf_reg <= '0;
    end else if (DEC_BIT_VALID_I) begin
      bitc_reg <= bitc_reg + 3'h1;
      if (fs_reg == FS_HUNT || fs_reg == FS_VERIFY) begin
        tmo_reg <= tmo_reg + 16'h1;
        if (tmo_reg == FS_TIMEOUT_BITS) fs_reg <= FS_FAIL;
      end
      if (fs_reg == FS_HUNT &&
          (sh_next == sync_val || sh_next == ~sync_val)) begin
        fs_reg <= FS_VERIFY;
        inv_reg <= sh_next != sync_val;
        bitc_reg <= '0;
        pos_reg <= 8'h1;
        conf_reg <= '0;
      end else if ((fs_reg == FS_VERIFY || fs_reg == FS_LOCK) &&
                   byte_done) begin
        pos_reg <= pos_reg == blk_len - 8'h1 ? 8'h0 : pos_reg + 8'h1;
        if (fs_reg == FS_VERIFY && pos_reg == 8'h0) begin
          if ((sh_next ^ {8{inv_reg}}) != sync_val) begin
            fs_reg <= FS_HUNT;
          end else if (conf_reg == LOCK_BLOCKS - 3'h1) begin
            fs_reg <= FS_LOCK;
          end else begin
            conf_reg <= conf_reg + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || ACQ_ABORT_I || FRAME_SYNC_GO_I) begin
      FRAME_LOCK_FLAG_O <= 1'b0;
      FRAME_SYNC_FAIL_FLAG_O <= 1'b0;
      FS_BYTE_O <= '0;
    end else begin
      FRAME_LOCK_FLAG_O <= fs_reg == FS_LOCK;
      FRAME_SYNC_FAIL_FLAG_O <= fs_reg == FS_FAIL;
      FS_BYTE_O.data <= sh_next ^ {8{inv_reg}};
      FS_BYTE_O.valid <= fs_reg == FS_LOCK && byte_done &&
                         !(ALT_FORMAT_I && pos_reg == 8'h0);
      FS_BYTE_O.sop <= ALT_FORMAT_I ? pos_reg == 8'h1 : pos_reg == 8'h0;
    end
  end

  // ===========================================================
  // pattern checker; decoder output when block decoder bypassed
  cdem_byte_t src;
  logic [7:0] ppos_reg;
  logic [PRBS_LEN-1:0] lfsr_reg, lfsr_nx;
  logic [3:0] perr;
  logic [2:0] pgood_reg;
  logic chk;
  assign src = BLOCK_DECODER_BYPASS_I ? FS_BYTE_O : BLK_BYTE_I;
  assign chk = src.valid && !src.sop &&
               ppos_reg >= {4'h0, PATTERN_HEADER_SKIP_I};

  // once in sync the register runs free so one error counts once
  always_comb begin
    logic b, p;
    b = 1'b0;
    p = 1'b0;
    lfsr_nx = lfsr_reg;
    perr = '0;
    for (int i = 7; i >= 0; i--) begin
      b = src.data[i];
      p = lfsr_nx[PRBS_LEN-1] ^ lfsr_nx[PRBS_TAP-1];
      perr = perr + {3'h0, b ^ p};
      lfsr_nx = {lfsr_nx[PRBS_LEN-2:0], PATTERN_SYNC_FLAG_O ? p : b};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || BLOCK_ERR_TYPE_SELECT_I != ERR_PRBS) begin
      ppos_reg <= '0;
      lfsr_reg <= '0;
      pgood_reg <= '0;
      PATTERN_SYNC_FLAG_O <= 1'b0;
    end else if (src.valid) begin
      ppos_reg <= src.sop ? 8'h1 : ppos_reg + 8'h1;
      if (chk) begin
        lfsr_reg <= lfsr_nx;
        if (perr != 4'h0) pgood_reg <= '0;
        else if (pgood_reg != PAT_CLEAN_BYTES)
          pgood_reg <= pgood_reg + 3'h1;
        if (pgood_reg == PAT_CLEAN_BYTES) PATTERN_SYNC_FLAG_O <= 1'b1;
      end
    end
  end

  // ===========================================================
  // block-code error counter
  logic [15:0] bwin_reg;
  logic [3:0] berr;
  logic bwin_end;
  always_comb begin
    unique case (BLOCK_ERR_TYPE_SELECT_I)
      ERR_BIT: berr = BLK_ERR_I.bit_errs;
      ERR_BYTE: berr = {3'h0, BLK_ERR_I.byte_err};
      ERR_PKT: berr = {3'h0, BLK_ERR_I.pkt_uncorr};
      ERR_PRBS: berr = chk && PATTERN_SYNC_FLAG_O ? perr : 4'h0;
    endcase
  end
  assign bwin_end = BLOCK_ERR_START_O && !BLOCK_ERR_WINDOW_MODE_I &&
                    BLK_ERR_I.pkt_done &&
                    bwin_reg + 16'h1 >= BLOCK_ERR_WINDOW_SIZE_I;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BLOCK_ERR_START_O <= 1'b0;
      BLOCK_ERR_COUNT_O <= '0;
      bwin_reg <= '0;
      BLOCK_ERR_DONE_O <= 1'b0;
    end else begin
      BLOCK_ERR_DONE_O <= bwin_end;
      if (BLOCK_ERR_START_SET_I) begin
        BLOCK_ERR_START_O <= 1'b1;
        BLOCK_ERR_COUNT_O <= '0;
        bwin_reg <= '0;
      end else if (BLOCK_ERR_START_O) begin
        if (BLOCK_ERR_START_CLR_I || bwin_end)
          BLOCK_ERR_START_O <= 1'b0;
        if (BLK_ERR_I.pkt_done) bwin_reg <= bwin_reg + 16'h1;
        BLOCK_ERR_COUNT_O <= sat_add(BLOCK_ERR_COUNT_O, berr);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) DEINTERLEAVER_BYPASS_O <= 1'b0;
    else DEINTERLEAVER_BYPASS_O <= DEINTERLEAVER_BYPASS_I;
  end

  // ===========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_dec_start;
    DECODER_ERR_START_SET_I;
  endsequence
  sequence s_try_hit;
    sr_reg == SR_TRY && rate_en && DEC_IN_SYNC_I && !ACQ_ABORT_I;
  endsequence

  a_lock_raise: assert property (s_try_hit |=> DECODER_LOCK_FLAG_O &&
    FOUND_STATUS_O == $past(HYP_O)) else $error("lock not flagged");
  a_fail_last: assert property (DECODER_SEARCH_FAIL_FLAG_O |->
    sr_reg == SR_FAIL || $past(ACQ_ABORT_I))
    else $error("fail flag without exhausted search");
  a_no_self: assert property (sr_reg == SR_IDLE && !DEC_SEARCH_GO_I |=>
    sr_reg == SR_IDLE) else $error("search started alone");
  a_dec_clear: assert property (s_dec_start |=> DECODER_ERR_COUNT_O == 16'h0
    && DECODER_ERR_START_O) else $error("start did not clear");
  a_dec_sat: assert property ($past(DECODER_ERR_COUNT_O) == CNT_MAX &&
    !$past(DECODER_ERR_START_SET_I) |-> DECODER_ERR_COUNT_O == CNT_MAX)
    else $error("decoder count wrapped");
  a_dec_window: assert property (dwin_end && !DECODER_ERR_START_SET_I |=>
    !DECODER_ERR_START_O && DECODER_ERR_DONE_O)
    else $error("window end kept start");
  a_blk_sat: assert property ($past(BLOCK_ERR_COUNT_O) == CNT_MAX &&
    !$past(BLOCK_ERR_START_SET_I) |-> BLOCK_ERR_COUNT_O == CNT_MAX)
    else $error("block count wrapped");
  a_blk_window: assert property (bwin_end && !BLOCK_ERR_START_SET_I |=>
    !BLOCK_ERR_START_O ##1
    (!BLOCK_ERR_START_O || $past(BLOCK_ERR_START_SET_I)))
    else $error("block window not closed");
  a_alt_strip: assert property (FS_BYTE_O.valid && ALT_FORMAT_I &&
    $past(ALT_FORMAT_I) |-> $past(pos_reg) != 8'h0)
    else $error("sync byte passed");

endmodule
`default_nettype wire

// *** cdem_far_model.sv ***
// Purpose: far side of the monitor: decoder core, bit stream, block bytes
// Assumes: everything changes 1 ns after the falling edge of the clock
// Notes: idle data lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module cdem_far_model
  import cdem_pkg::*;
(
  input wire logic clk_i,
  input wire cdem_hyp_t hyp_i,
  input wire cdem_hyp_t lock_hyp_i,
  input wire logic sync_en_i,
  input wire logic alt_i,
  input wire logic inv_i,
  input wire logic bits_en_i,
  input wire logic pat_en_i,
  input wire logic pat_flip_i,
  input wire logic [3:0] skip_i,
  output logic in_sync_o,
  output logic bit_vld_o,
  output logic bit_o,
  output cdem_byte_t byte_o
);
  logic [7:0] pos_reg = 8'h0;
  logic [2:0] bit_reg = 3'h0;
  logic [7:0] pkt_reg = 8'h0;
  logic [22:0] lfsr_reg = 23'h1;
  logic flip_reg = 1'b0;
  logic [7:0] cur;
  logic [7:0] pb;
  int i;
  initial begin
    in_sync_o = 1'b0;
    bit_vld_o = 1'b0;
    bit_o = 1'b0;
    byte_o = '0;
  end
  // ==========================================
  // decoder core: sync only on the right trial
  always @(negedge clk_i) begin
    // wait for the bench's falling-edge drive, else a race picks the value
    #1;
    in_sync_o <= sync_en_i && (hyp_i === lock_hyp_i);
  end
  // ==========================================
  // coded blocks, msb first, sync byte leading
  always @(negedge clk_i) begin
    #1;
    if (!bits_en_i) begin
      pos_reg <= 8'h0;
      bit_reg <= 3'h0;
      bit_vld_o <= 1'b0;
      bit_o <= !bit_o;
    end else begin
      cur = (pos_reg == 8'h0) ?
            (alt_i ? SYNC_ALT : SYNC_MAIN) : 8'h0f;
      bit_o <= cur[3'h7 - bit_reg] ^ inv_i;
      bit_vld_o <= 1'b1;
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == 3'h7) begin
        if (pos_reg == (alt_i ? BLK_LEN_ALT : BLK_LEN_MAIN) - 8'h1)
          pos_reg <= 8'h0;
        else
          pos_reg <= pos_reg + 8'h1;
      end
    end
  end
  // ==========================================
  // test packets: pattern runs on checked bytes only
  always @(negedge clk_i) begin
    #1;
    flip_reg = flip_reg | pat_flip_i;
    if (!pat_en_i) begin
      pkt_reg = 8'h0;
      byte_o.valid <= 1'b0;
      byte_o.sop <= 1'b0;
      byte_o.data <= ~byte_o.data;
    end else begin
      pb = (pkt_reg == 8'h0) ? SYNC_MAIN : 8'ha5;
      if (pkt_reg != 8'h0 && pkt_reg >= {4'h0, skip_i}) begin
        for (i = 0; i < 8; i++) begin
          pb = {pb[6:0], lfsr_reg[22] ^ lfsr_reg[17]};
          lfsr_reg = {lfsr_reg[21:0], pb[0]};
        end
        pb[0] = pb[0] ^ flip_reg;
        flip_reg = 1'b0;
      end
      byte_o.data <= pb;
      byte_o.valid <= 1'b1;
      byte_o.sop <= (pkt_reg == 8'h0);
      pkt_reg = (pkt_reg == 8'hbb) ? 8'h0 : pkt_reg + 8'h1;
    end
  end
endmodule
`default_nettype wire

// *** test_channel_decoder_error_monitor.sv ***
// Purpose: self-checking bench for the channel decoder monitor
// Assumes: inputs change on the falling edge of CLK_I
// Notes: searches run at full dwell, so the run takes about 65k cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_channel_decoder_error_monitor
  import cdem_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, s_go = 1'b0, f_go = 1'b0, abort = 1'b0;
  logic alt = 1'b0, tb_vld = 1'b0, berr = 1'b0, d_mode = 1'b0;
  logic d_set = 1'b0, d_clr = 1'b0, b_mode = 1'b0, b_set = 1'b0;
  logic b_clr = 1'b0, block_decoder_bypass = 1'b0, deinterleaver_bypass = 1'b0, sync_en = 1'b0;
  logic inv = 1'b0, bits_en = 1'b0, pat_en = 1'b0, flip = 1'b0;
  logic [4:0] sel = 5'h1;
  logic [15:0] d_size = 16'h0, b_size = 16'h0;
  logic [3:0] skip = 4'h0;
  cdem_errtype_t b_type = ERR_BIT;
  cdem_blkerr_t blk = '0;
  cdem_hyp_t want = '0, hyp, found;
  cdem_byte_t fs_byte, blk_byte;
  logic lock, fail, d_start, d_done, b_start, b_done, psync, flock, ffail;
  logic di_out, fm_vld, fm_bit, in_sync;
  logic [15:0] d_cnt, b_cnt;
  wire logic vld;
  int mismatches = 0, compares = 0, cycles = 0, n, k;
  assign vld = fm_vld | tb_vld;
  always #10 clk = ~clk;
  cdem_top u_cdem_top (
    .CLK_I(clk), .RST_I(rst), .DEC_SEARCH_GO_I(s_go),
    .FRAME_SYNC_GO_I(f_go), .ACQ_ABORT_I(abort), .CODE_RATE_SELECT_I(sel),
    .DEC_IN_SYNC_I(in_sync), .DEC_BIT_VALID_I(vld), .DEC_BIT_I(fm_bit),
    .DEC_BIT_ERR_I(berr), .ALT_FORMAT_I(alt),
    .DECODER_ERR_WINDOW_MODE_I(d_mode), .DECODER_ERR_WINDOW_SIZE_I(d_size),
    .DECODER_ERR_START_SET_I(d_set), .DECODER_ERR_START_CLR_I(d_clr),
    .BLOCK_ERR_TYPE_SELECT_I(b_type), .BLOCK_ERR_WINDOW_MODE_I(b_mode),
    .BLOCK_ERR_WINDOW_SIZE_I(b_size), .BLOCK_ERR_START_SET_I(b_set),
    .BLOCK_ERR_START_CLR_I(b_clr), .BLK_ERR_I(blk), .BLK_BYTE_I(blk_byte),
    .PATTERN_HEADER_SKIP_I(skip), .BLOCK_DECODER_BYPASS_I(block_decoder_bypass),
    .DEINTERLEAVER_BYPASS_I(deinterleaver_bypass), .HYP_O(hyp), .DECODER_LOCK_FLAG_O(lock),
    .DECODER_SEARCH_FAIL_FLAG_O(fail), .FOUND_STATUS_O(found),
    .DECODER_ERR_COUNT_O(d_cnt), .DECODER_ERR_START_O(d_start),
    .DECODER_ERR_DONE_O(d_done), .BLOCK_ERR_COUNT_O(b_cnt),
    .BLOCK_ERR_START_O(b_start), .BLOCK_ERR_DONE_O(b_done),
    .PATTERN_SYNC_FLAG_O(psync), .FRAME_LOCK_FLAG_O(flock),
    .FRAME_SYNC_FAIL_FLAG_O(ffail), .FS_BYTE_O(fs_byte),
    .DEINTERLEAVER_BYPASS_O(di_out));
  cdem_far_model u_cdem_far_model (
    .clk_i(clk), .hyp_i(hyp), .lock_hyp_i(want), .sync_en_i(sync_en),
    .alt_i(alt), .inv_i(inv), .bits_en_i(bits_en), .pat_en_i(pat_en),
    .pat_flip_i(flip), .skip_i(skip), .in_sync_o(in_sync),
    .bit_vld_o(fm_vld), .bit_o(fm_bit), .byte_o(blk_byte));
  // ==========================================
  // helpers
  task cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  task finish_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one hunt, then byte count from one block start to the next
  task fs_run(input logic a, input logic iv);
    int c;
    alt = a;
    inv = iv;
    bits_en = 1'b1;
    f_go = 1'b1;
    cyc(1);
    f_go = 1'b0;
    for (n = 0; n < 9000 && flock !== 1'b1; n++) cyc(1);
    `CHK(n >= (a ? 3528 : 4896), 1'b1)
    `CHK({flock, ffail}, 2'h2)
    for (n = 0; n < 3000 && {fs_byte.valid, fs_byte.sop} !== 2'h3; n++) cyc(1);
    `CHK(fs_byte.data, a ? 8'h0f : SYNC_MAIN)
    c = 0;
    cyc(1);
    for (n = 0; n < 3000 && {fs_byte.valid, fs_byte.sop} !== 2'h3; n++) begin
      c += (fs_byte.valid === 1'b1);
      cyc(1);
    end
    `CHK(c, a ? 145 : 203)
    bits_en = 1'b0;
    $display("frame test alt=%0d inv=%0d done", a, iv);
  endtask
  // ==========================================
  // timeout: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      finish_test();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    cyc(5);
    `CHK({lock, fail, d_start, b_start, flock, ffail, psync, d_cnt}, 23'h0)
    rst = 1'b0;
    sync_en = 1'b1;
    cyc(20);
    `CHK(lock, 1'b0)
    want = {3'h4, 2'h2, 1'b1, 1'b0};
    sel = 5'h18;
    s_go = 1'b1;
    cyc(1);
    s_go = 1'b0;
    for (n = 0; n < 30000 && lock !== 1'b1; n++) cyc(1);
    `CHK({lock, fail}, 2'h2)
    `CHK(found, want)
    sel = 5'h0;
    s_go = 1'b1;
    cyc(1);
    s_go = 1'b0;
    for (n = 0; n < 100 && fail !== 1'b1; n++) cyc(1);
    `CHK({fail, lock}, 2'h2)
    abort = 1'b1;
    cyc(1);
    abort = 1'b0;
    cyc(2);
    `CHK(fail, 1'b0)
    $display("search test done");
    d_size = 16'ha;
    d_set = 1'b1;
    cyc(1);
    d_set = 1'b0;
    `CHK({d_start, d_cnt}, 17'h10000)
    for (k = 0; k < 10; k++) begin
      tb_vld = 1'b1;
      berr = (k % 3 == 0);
      cyc(1);
    end
    tb_vld = 1'b0;
    `CHK({d_start, d_done, d_cnt}, 18'h10004)
    cyc(1);
    `CHK(d_done, 1'b0)
    tb_vld = 1'b1;
    berr = 1'b1;
    cyc(3);
    tb_vld = 1'b0;
    `CHK(d_cnt, 16'h4)
    d_mode = 1'b1;
    d_set = 1'b1;
    cyc(1);
    d_set = 1'b0;
    `CHK(d_cnt, 16'h0)
    tb_vld = 1'b1;
    cyc(20);
    tb_vld = 1'b0;
    d_clr = 1'b1;
    cyc(1);
    d_clr = 1'b0;
    berr = 1'b0;
    `CHK({d_start, d_cnt}, 17'h00014)
    $display("decoder counter test done");
    b_size = 16'h3;
    for (k = 0; k < 3; k++) begin
      b_type = cdem_errtype_t'(k[1:0]);
      b_set = 1'b1;
      cyc(1);
      b_set = 1'b0;
      for (n = 0; n < 3; n++) begin
        blk = {4'h5, 1'b1, n != 1, 1'b1};
        cyc(1);
      end
      blk = '0;
      `CHK({b_start, b_done, b_cnt},
           {2'h1, k == 0 ? 16'hf : k == 1 ? 16'h3 : 16'h2})
    end
    b_type = ERR_BIT;
    b_mode = 1'b1;
    b_set = 1'b1;
    cyc(1);
    b_set = 1'b0;
    blk.bit_errs = 4'hf;
    cyc(4400);
    blk = '0;
    `CHK(b_cnt, CNT_MAX)
    b_clr = 1'b1;
    cyc(1);
    b_clr = 1'b0;
    `CHK(b_start, 1'b0)
    $display("block counter test done");
    fs_run(1'b0, 1'b0);
    fs_run(1'b0, 1'b1);
    fs_run(1'b1, 1'b0);
    tb_vld = 1'b1;
    f_go = 1'b1;
    cyc(1);
    f_go = 1'b0;
    for (n = 0; n < 8400 && ffail !== 1'b1; n++) cyc(1);
    tb_vld = 1'b0;
    `CHK({flock, ffail}, 2'h1)
    $display("frame fail test done");
    skip = 4'h3;
    b_type = ERR_PRBS;
    pat_en = 1'b1;
    for (n = 0; n < 3000 && psync !== 1'b1; n++) cyc(1);
    `CHK(psync, 1'b1)
    b_set = 1'b1;
    cyc(1);
    b_set = 1'b0;
    cyc(300);
    `CHK(b_cnt, 16'h0)
    flip = 1'b1;
    cyc(1);
    flip = 1'b0;
    cyc(400);
    `CHK(b_cnt, 16'h1)
    deinterleaver_bypass = 1'b1;
    cyc(2);
    `CHK(di_out, 1'b1)
    $display("pattern test done");
    finish_test();
  end
endmodule
`default_nettype wire
